// ==== design/tcss_timer.sv ====
// timer clock select, counters and control/status register
//
// Summary of operation
// - low select code 000 counts external event pin edges
// - codes 100-111 pick div32, div16, div4, sub/4
// - edge polarity follows external edge select bit
// - gated pin edge detect, spurious count possible
// - control/status resets to all zeros
// - flags clear by zero write, one ignored
// - zero write clears only after flag read
// - high overflow flag on high byte wrap
// - high match flag on high or full compare equality
// - bit 5 enables high overflow request
// - bit 4 clears full or high counter
// - 8-bit mode low overflow flag on low byte wrap
// - 8-bit mode low match flag on low compare equality
// - bit 1 enables low overflow request
// - bit 0 clears low counter on 8-bit mode match
// - high select top bit picks 8-bit mode
// - 16-bit mode full wrap sets high overflow
`include "tcss_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module tcss_timer (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             csr_wr,
   input  wire logic             csr_rd,
   input  wire logic             ctrl_wr,
   input  wire tcss_pkg::tcss_byte_t wr_data,
   output var  tcss_pkg::tcss_byte_t rd_data,
   input  wire logic             event_input_pin,
   input  wire logic             event_edge_select,
   input  wire logic             event_pin_function_bit,
   input  wire logic             sub_tick,
   input  wire tcss_pkg::tcss_byte_t high_compare,
   input  wire tcss_pkg::tcss_byte_t low_compare,
   output var  tcss_pkg::tcss_byte_t high_counter,
   output var  tcss_pkg::tcss_byte_t low_counter,
   output var  logic             high_ovf_req,
   output var  logic             low_ovf_req
);
   import tcss_pkg::*;

   // ****************************************
   // state
   // ****************************************
   tcss_byte_t    csr;
   tcss_byte_t    arm;
   tcss_byte_t    ctrl;
   logic [4:0]    presc;
   logic [1:0]    sub_cnt;
   logic          evt_prev;
   tcss_byte_t    next_csr;
   tcss_byte_t    next_arm;
   tcss_byte_t    next_ctrl;
   logic [4:0]    next_presc;
   logic [1:0]    next_sub_cnt;
   logic          next_evt_prev;
   tcss_byte_t    next_rd_data;
   tcss_byte_t    next_high;
   tcss_byte_t    next_low;
   logic          next_high_req;
   logic          next_low_req;

   // ****************************************
   // clock selection
   // ****************************************
   tcss_clk_sel_e low_sel;
   tcss_clk_sel_e high_sel;
   logic          mode8;
   logic          gated_pin;
   logic          ext_edge;
   logic          div32_tick;
   logic          div16_tick;
   logic          div4_tick;
   logic          sub4_tick;
   logic          low_tick;
   logic          high_tick;
   logic [15:0]   full_cnt;
   logic [15:0]   full_next_inc;
   logic          full_match;
   logic          low_match;
   logic          high_match;
   tcss_byte_t    set_mask;
   tcss_byte_t    clr_mask;

   function automatic logic sel_tick(input tcss_clk_sel_e sel, input logic ext,
                                     input logic t32, input logic t16,
                                     input logic t4, input logic ts);
      logic t;
      t = 1'b0;
      case (sel)
         TCSS_SEL_EXT:   t = ext;
         TCSS_SEL_DIV32: t = t32;
         TCSS_SEL_DIV16: t = t16;
         TCSS_SEL_DIV4:  t = t4;
         TCSS_SEL_SUB4:  t = ts;
         default:        t = 1'b0;
      endcase
      return t;
   endfunction : sel_tick

   always_comb begin
      low_sel    = tcss_clk_sel_e'(ctrl[`TCSS_LSEL_MSB:`TCSS_LSEL_LSB]);
      high_sel   = tcss_clk_sel_e'(ctrl[`TCSS_HSEL_MSB:`TCSS_HSEL_LSB]);
      mode8      = ctrl[`TCSS_MODE8_BIT];
      // pin reads high while its function is off
      gated_pin  = event_pin_function_bit ? event_input_pin : 1'b1;
      ext_edge   = event_edge_select ? (gated_pin & ~evt_prev)
                                     : (~gated_pin & evt_prev);
      div32_tick = (presc == `TCSS_DIV32_LAST);
      div16_tick = (presc[3:0] == `TCSS_DIV16_LAST);
      div4_tick  = (presc[1:0] == `TCSS_DIV4_LAST);
      sub4_tick  = sub_tick && (sub_cnt == `TCSS_DIV4_LAST);
      low_tick   = sel_tick(low_sel, ext_edge, div32_tick, div16_tick,
                            div4_tick, sub4_tick);
      // in 8-bit mode the high half has no external input
      high_tick  = mode8 && sel_tick(high_sel, 1'b0, div32_tick, div16_tick,
                                     div4_tick, sub4_tick);
      full_cnt      = {high_counter, low_counter};
      full_next_inc = full_cnt + `TCSS_ONE16;
      full_match    = (full_cnt == {high_compare, low_compare});
      low_match     = (low_counter == low_compare);
      high_match    = (high_counter == high_compare);
   end

   // ****************************************
   // counters and prescalers
   // ****************************************
   always_comb begin
      next_presc    = presc + `TCSS_PRESC_ONE;
      next_sub_cnt  = sub_tick ? sub_cnt + `TCSS_SUB_ONE : sub_cnt;
      next_evt_prev = gated_pin;
      next_high     = high_counter;
      next_low      = low_counter;
      if (mode8) begin
         if (low_tick) begin
            next_low = (low_match && csr[`TCSS_LOW_CLEAR_ON_MATCH]) ? `TCSS_ZERO8
                                                       : low_counter + `TCSS_ONE8;
         end
         if (high_tick) begin
            next_high = (high_match && csr[`TCSS_HIGH_CLEAR_ON_MATCH]) ? `TCSS_ZERO8
                                                         : high_counter + `TCSS_ONE8;
         end
      end else if (low_tick) begin
         if (full_match && csr[`TCSS_HIGH_CLEAR_ON_MATCH]) begin
            next_high = `TCSS_ZERO8;
            next_low  = `TCSS_ZERO8;
         end else begin
            next_high = full_next_inc[15:8];
            next_low  = full_next_inc[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         presc        <= `TCSS_PRESC_RST;
         sub_cnt      <= `TCSS_SUB_RST;
         evt_prev     <= 1'b1;
         high_counter <= `TCSS_CNT_RST;
         low_counter  <= `TCSS_CNT_RST;
      end else begin
         presc        <= next_presc;
         sub_cnt      <= next_sub_cnt;
         evt_prev     <= next_evt_prev;
         high_counter <= next_high;
         low_counter  <= next_low;
      end
   end

   // ****************************************
   // control/status register
   // ****************************************
   always_comb begin
      set_mask = `TCSS_ZERO8;
      if (mode8) begin
         set_mask[`TCSS_HIGH_OVERFLOW_FLAG] = high_tick && (high_counter == `TCSS_BYTE_MAX);
         set_mask[`TCSS_HIGH_MATCH_FLAG] = high_tick && high_match;
         set_mask[`TCSS_LOW_OVERFLOW_FLAG] = low_tick && (low_counter == `TCSS_BYTE_MAX);
         set_mask[`TCSS_LOW_MATCH_FLAG] = low_tick && low_match;
      end else begin
         set_mask[`TCSS_HIGH_OVERFLOW_FLAG] = low_tick && (full_cnt == `TCSS_FULL_MAX);
         set_mask[`TCSS_HIGH_MATCH_FLAG] = low_tick && full_match;
      end
      // only armed flags clear, and only by a zero
      clr_mask  = csr_wr ? (~wr_data & arm & `TCSS_FLAG_MASK) : `TCSS_ZERO8;
      // hardware set wins over a clear in the same cycle
      next_csr  = ((csr & ~clr_mask) | set_mask) & `TCSS_FLAG_MASK;
      next_csr  = next_csr | ((csr_wr ? wr_data : csr) & ~`TCSS_FLAG_MASK);
      next_arm  = csr_wr ? `TCSS_ZERO8
                         : (arm | (csr_rd ? (csr & `TCSS_FLAG_MASK) : `TCSS_ZERO8));
      next_ctrl = ctrl_wr ? wr_data : ctrl;
      next_rd_data  = csr_rd ? csr : rd_data;
      next_high_req = csr[`TCSS_HIGH_OVERFLOW_FLAG] && csr[`TCSS_HIGH_OVERFLOW_INT_EN];
      next_low_req  = csr[`TCSS_LOW_OVERFLOW_FLAG] && csr[`TCSS_LOW_OVERFLOW_INT_EN];
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         csr          <= `TCSS_CSR_RST;
         arm          <= `TCSS_ZERO8;
         ctrl         <= `TCSS_CTRL_RST;
         rd_data      <= `TCSS_ZERO8;
         high_ovf_req <= 1'b0;
         low_ovf_req  <= 1'b0;
      end else begin
         csr          <= next_csr;
         arm          <= next_arm;
         ctrl         <= next_ctrl;
         rd_data      <= next_rd_data;
         high_ovf_req <= next_high_req;
         low_ovf_req  <= next_low_req;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   reset_zero_a: assert property (disable iff (1'b0) srst |=> csr == `TCSS_CSR_RST)
      else $error("status not zero after reset");
   // in 16-bit mode the low half steps with the full counter unless it clears
   ext_count_a: assert property (low_sel == TCSS_SEL_EXT && ext_edge
         && !(mode8 ? (low_match && csr[`TCSS_LOW_CLEAR_ON_MATCH])
                    : (full_match && csr[`TCSS_HIGH_CLEAR_ON_MATCH]))
         |=> low_counter == 8'($past(low_counter) + `TCSS_ONE8))
      else $error("external edge not counted");
   div32_tick_a: assert property (low_sel == TCSS_SEL_DIV32 && low_tick
         |=> !low_tick [*8])
      else $error("div32 ticks too often");
   pin_edge_a: assert property (event_edge_select && event_pin_function_bit
         && !evt_prev && event_input_pin |-> ext_edge)
      else $error("rising edge missed");
   func_edge_a: assert property (!event_edge_select && !event_pin_function_bit
         ##1 event_pin_function_bit && !event_input_pin |-> ext_edge)
      else $error("pin function edge not seen");
   write_one_a: assert property (csr_wr && !csr[`TCSS_LOW_OVERFLOW_FLAG] && !set_mask[`TCSS_LOW_OVERFLOW_FLAG]
         |=> !csr[`TCSS_LOW_OVERFLOW_FLAG])
      else $error("flag set by software");
   unarmed_hold_a: assert property (csr_wr && !arm[`TCSS_HIGH_MATCH_FLAG] && csr[`TCSS_HIGH_MATCH_FLAG]
         |=> csr[`TCSS_HIGH_MATCH_FLAG])
      else $error("flag cleared without read");
   // read, one idle cycle, then the zero write that must clear
   armed_clear_a: assert property (csr_rd && csr[`TCSS_HIGH_OVERFLOW_FLAG] ##1 !csr_wr ##1 csr_wr
         && !wr_data[`TCSS_HIGH_OVERFLOW_FLAG] && !set_mask[`TCSS_HIGH_OVERFLOW_FLAG] |=> !csr[`TCSS_HIGH_OVERFLOW_FLAG])
      else $error("armed flag not cleared");
   high_wrap_a: assert property (mode8 && high_tick && high_counter == `TCSS_BYTE_MAX
         |=> csr[`TCSS_HIGH_OVERFLOW_FLAG] && high_counter == `TCSS_ZERO8)
      else $error("high wrap missed");
   high_match_a: assert property (mode8 && high_tick && high_match
         |=> csr[`TCSS_HIGH_MATCH_FLAG])
      else $error("high match missed");
   high_req_a: assert property (csr[`TCSS_HIGH_OVERFLOW_FLAG] && csr[`TCSS_HIGH_OVERFLOW_INT_EN] [*2]
         |-> high_ovf_req)
      else $error("high request missing");
   full_clear_a: assert property (!mode8 && low_tick && full_match && csr[`TCSS_HIGH_CLEAR_ON_MATCH]
         |=> full_cnt == `TCSS_ZERO16)
      else $error("full counter not cleared");
   low_wrap_a: assert property (mode8 && low_tick && low_counter == `TCSS_BYTE_MAX
         |=> csr[`TCSS_LOW_OVERFLOW_FLAG])
      else $error("low wrap missed");
   low_match_a: assert property (mode8 && low_tick && low_match
         |=> csr[`TCSS_LOW_MATCH_FLAG])
      else $error("low match missed");
   low_req_a: assert property (!csr[`TCSS_LOW_OVERFLOW_INT_EN] |=> !low_ovf_req)
      else $error("low request while disabled");
   low_clear_a: assert property (mode8 && low_tick && low_match && csr[`TCSS_LOW_CLEAR_ON_MATCH]
         |=> low_counter == `TCSS_ZERO8)
      else $error("low counter not cleared");
   mode16_a: assert property (!mode8 |-> !set_mask[`TCSS_LOW_OVERFLOW_FLAG] && !set_mask[`TCSS_LOW_MATCH_FLAG])
      else $error("low flag set in 16-bit mode");
   full_wrap_a: assert property (!mode8 && low_tick && full_cnt == `TCSS_FULL_MAX
         |=> csr[`TCSS_HIGH_OVERFLOW_FLAG] && full_cnt == `TCSS_ZERO16)
      else $error("full wrap missed");
   high_clear_a: assert property (mode8 && high_tick && high_match && csr[`TCSS_HIGH_CLEAR_ON_MATCH]
         |=> high_counter == `TCSS_ZERO8)
      else $error("high counter not cleared");
   high_req_off_a: assert property (!csr[`TCSS_HIGH_OVERFLOW_INT_EN] |=> !high_ovf_req)
      else $error("high request while disabled");
   low_req_on_a: assert property (csr[`TCSS_LOW_OVERFLOW_FLAG] && csr[`TCSS_LOW_OVERFLOW_INT_EN]
         |=> low_ovf_req)
      else $error("low request missing");
   flag_hold_a: assert property (!csr_wr
         |=> ($past(csr) & ~csr & `TCSS_FLAG_MASK) == `TCSS_ZERO8)
      else $error("flag dropped without write");
   csr_write_a: assert property (csr_wr
         |=> (csr & ~`TCSS_FLAG_MASK) == ($past(wr_data) & ~`TCSS_FLAG_MASK))
      else $error("enable bits not written");
   read_data_a: assert property (csr_rd |=> rd_data == $past(csr))
      else $error("read data not status");
   ctrl_load_a: assert property (ctrl_wr |=> ctrl == $past(wr_data))
      else $error("timer control not loaded");

endmodule : tcss_timer

`default_nettype wire

// ==== design/tcss_defs.svh ====
// constants for the timer clock select and control/status block
`ifndef TCSS_DEFS_SVH
`define TCSS_DEFS_SVH

// control/status field positions
`define TCSS_HIGH_OVERFLOW_FLAG        7
`define TCSS_HIGH_MATCH_FLAG        6
`define TCSS_HIGH_OVERFLOW_INT_EN       5
`define TCSS_HIGH_CLEAR_ON_MATCH       4
`define TCSS_LOW_OVERFLOW_FLAG        3
`define TCSS_LOW_MATCH_FLAG        2
`define TCSS_LOW_OVERFLOW_INT_EN       1
`define TCSS_LOW_CLEAR_ON_MATCH       0
`define TCSS_FLAG_MASK   8'hCC

// timer control field positions
`define TCSS_HSEL_MSB    6
`define TCSS_HSEL_LSB    4
`define TCSS_LSEL_MSB    2
`define TCSS_LSEL_LSB    0
`define TCSS_MODE8_BIT   6

// reset values
`define TCSS_CSR_RST     8'h00
`define TCSS_CTRL_RST    8'h00
`define TCSS_CNT_RST     8'h00
`define TCSS_ZERO8       8'h00

// counter limits and steps
`define TCSS_BYTE_MAX    8'hFF
`define TCSS_FULL_MAX    16'hFFFF
`define TCSS_ONE8        8'h01
`define TCSS_ONE16       16'h0001
`define TCSS_ZERO16      16'h0000

// prescaler terminal counts
`define TCSS_PRESC_RST   5'h00
`define TCSS_PRESC_ONE   5'h01
`define TCSS_DIV32_LAST  5'h1F
`define TCSS_DIV16_LAST  4'hF
`define TCSS_DIV4_LAST   2'h3
`define TCSS_SUB_RST     2'h0
`define TCSS_SUB_ONE     2'h1

`endif

// ==== design/tcss_pkg.sv ====
// types for the timer clock select and control/status block
package tcss_pkg;

   typedef enum logic [2:0] {
      TCSS_SEL_EXT   = 3'b000,
      TCSS_SEL_R1    = 3'b001,
      TCSS_SEL_R2    = 3'b010,
      TCSS_SEL_NA    = 3'b011,
      TCSS_SEL_DIV32 = 3'b100,
      TCSS_SEL_DIV16 = 3'b101,
      TCSS_SEL_DIV4  = 3'b110,
      TCSS_SEL_SUB4  = 3'b111
   } tcss_clk_sel_e;

   typedef logic [7:0] tcss_byte_t;

endpackage : tcss_pkg

// ==== sim/tcss_cpu_model.sv ====
// cpu side model: byte-wide register accesses to the timer block
`timescale 1ns/1ns
`default_nettype none

module tcss_cpu_model (
   input  wire logic                 ref_clk,
   output var  logic                 csr_wr,
   output var  logic                 csr_rd,
   output var  logic                 ctrl_wr,
   output var  tcss_pkg::tcss_byte_t wr_data,
   input  wire tcss_pkg::tcss_byte_t rd_data
);
   import tcss_pkg::*;

   initial begin
      csr_wr  = 1'b0;
      csr_rd  = 1'b0;
      ctrl_wr = 1'b0;
      wr_data = 8'h00;
   end

   // ***********************************
   // bus cycles, one strobe cycle each
   // ***********************************
   // released data shows the inverse so stale values never look valid
   task wr_csr(input tcss_byte_t d);
      @(negedge ref_clk);
      wr_data = d;
      csr_wr  = 1'b1;
      @(negedge ref_clk);
      csr_wr  = 1'b0;
      wr_data = ~d;
   endtask : wr_csr

   // callers only use codes 000 and 100 to 111
   task wr_ctrl(input tcss_byte_t d);
      @(negedge ref_clk);
      wr_data = d;
      ctrl_wr = 1'b1;
      @(negedge ref_clk);
      ctrl_wr = 1'b0;
      wr_data = ~d;
   endtask : wr_ctrl

   // a flag is read as one before a zero is written to clear it
   task rd_csr(output tcss_byte_t v);
      @(negedge ref_clk);
      csr_rd = 1'b1;
      @(negedge ref_clk);
      csr_rd = 1'b0;
      v      = rd_data;
   endtask : rd_csr

endmodule : tcss_cpu_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking testbench for the timer clock select and control/status block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   import tcss_pkg::*;

   logic       ref_clk = 1'b0;
   logic       srst    = 1'b1;
   logic       pin;
   logic       esel;
   logic       pfun;
   logic       sub_tick;
   logic       sub_en  = 1'b1;
   logic       csr_wr, csr_rd, ctrl_wr, hreq, lreq;
   tcss_byte_t wr_data, rd_data, hcnt, lcnt;
   tcss_byte_t hcmp;
   tcss_byte_t lcmp;
   int         fail_count = 0;
   int         num_checks = 0;

   always #2 ref_clk = ~ref_clk;
   always @(negedge ref_clk) sub_tick <= sub_en && (sub_tick !== 1'b1);

   tcss_cpu_model cpu (.ref_clk(ref_clk), .csr_wr(csr_wr), .csr_rd(csr_rd), .ctrl_wr(ctrl_wr),
                       .wr_data(wr_data), .rd_data(rd_data));

   tcss_timer DUT (.ref_clk(ref_clk), .srst(srst), .csr_wr(csr_wr), .csr_rd(csr_rd),
                   .ctrl_wr(ctrl_wr), .wr_data(wr_data), .rd_data(rd_data),
                   .event_input_pin(pin), .event_edge_select(esel),
                   .event_pin_function_bit(pfun), .sub_tick(sub_tick),
                   .high_compare(hcmp), .low_compare(lcmp), .high_counter(hcnt),
                   .low_counter(lcnt), .high_ovf_req(hreq), .low_ovf_req(lreq));

   // ***********************************
   // helpers
   // ***********************************
   task check(input string name, input tcss_byte_t seen, input tcss_byte_t exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task results;
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc

   task do_reset;
      srst = 1'b1;
      cyc(16);
      srst = 1'b0;
   endtask : do_reset

   task pulse(input int n);
      repeat (n) begin
         pin = 1'b0;
         cyc(4);
         pin = 1'b1;
         cyc(4);
      end
   endtask : pulse

   // ***********************************
   // scenarios
   // ***********************************
   task t_reset;
      tcss_byte_t v;
      cpu.rd_csr(v);
      check("csr", v, 8'h00);
      check("low_counter", lcnt, 8'h00);
      check("reqs", {6'h00, hreq, lreq}, 8'h00);
   endtask : t_reset

   task t_event;
      pulse(3);
      check("low_counter", lcnt, 8'h03);
      esel = 1'b0;
      pulse(2);
      check("low_counter", lcnt, 8'h05);
      pfun = 1'b0;
      cyc(2);
      pin = 1'b0;
      cyc(4);
      pfun = 1'b1;
      cyc(4);
      pin = 1'b1;
      cyc(4);
      check("low_counter", lcnt, 8'h06);
      check("high_counter", hcnt, 8'h00);
   endtask : t_event

   task t_div;
      tcss_byte_t a;
      tcss_byte_t h;
      tcss_byte_t exp_t [4] = '{8'h04, 8'h08, 8'h20, 8'h10};
      for (int c = 4; c < 8; c++) begin
         cpu.wr_ctrl({1'b0, c[2:0], 1'b0, c[2:0]});
         cyc(4);
         a = lcnt;
         h = hcnt;
         cyc(128);
         check("low ticks", lcnt - a, exp_t[c-4]);
         check("high ticks", hcnt - h, exp_t[c-4]);
      end
   endtask : t_div

   task t_flags;
      tcss_byte_t v;
      logic       bad;
      do_reset();
      bad  = 1'b0;
      hcmp = 8'h80;
      lcmp = 8'h05;
      cpu.wr_csr(8'h23);
      cpu.wr_ctrl(8'h66);
      repeat (1100) begin
         cyc(1);
         bad = bad | (lcnt > 8'h05);
      end
      check("low clear", {7'h00, bad}, 8'h00);
      sub_en = 1'b0;
      cpu.wr_ctrl(8'h77);
      cyc(4);
      cpu.rd_csr(v);
      check("csr", v, 8'hE7);
      check("high req", {7'h00, hreq}, 8'h01);
      check("low req", {7'h00, lreq}, 8'h00);
      cpu.wr_csr(8'hC7);
      cyc(2);
      check("high req", {7'h00, hreq}, 8'h00);
      cpu.wr_csr(8'h03);
      cpu.rd_csr(v);
      check("csr", v, 8'hC7);
      cpu.wr_csr(8'h03);
      cpu.rd_csr(v);
      check("csr", v, 8'h03);
      cpu.wr_csr(8'hCF);
      cpu.rd_csr(v);
      check("csr", v, 8'h03);
   endtask : t_flags

   task t_clear16;
      tcss_byte_t v;
      logic       bad;
      do_reset();
      bad  = 1'b0;
      hcmp = 8'h00;
      lcmp = 8'h07;
      cpu.wr_csr(8'h10);
      cpu.wr_ctrl(8'h06);
      repeat (200) begin
         cyc(1);
         bad = bad | (hcnt != 8'h00) | (lcnt > 8'h07);
      end
      check("full clear", {7'h00, bad}, 8'h00);
      cpu.rd_csr(v);
      check("csr", v, 8'h50);
   endtask : t_clear16

   // ***********************************
   // main sequence and watchdog
   // ***********************************
   initial begin
      pin  = 1'b1;
      esel = 1'b1;
      pfun = 1'b1;
      hcmp = 8'hFF;
      lcmp = 8'hFF;
      do_reset();
      t_reset();
      t_event();
      t_div();
      t_flags();
      t_clear16();
      results();
   end

   initial begin
      #40000;
      fail_count++;
      results();
   end

endmodule : tb_top
`default_nettype wire
